// ---- rtl/two_wire_pkg.sv ----
// constants, states and register layout of the byte-level two-wire controller
package two_wire_pkg;
  localparam logic [7:0] STATUS_CONTROL_OFFSET = 8'h28;
  localparam logic [7:0] BYTE_BUFFER_OFFSET = 8'h29;
  localparam int ENABLE_BIT = 0;
  localparam int RECEIVED_STOP_BIT = 1;
  localparam int CONTEST_LOST_OR_REPEAT_START_BIT = 2;
  localparam int ADDRESS_PHASE_BIT = 3;
  localparam int ACK_BIT = 4;
  localparam int TRANSMIT_BIT = 5;
  localparam int PROCEED_BIT = 6;
  localparam int MASTER_SELECT_BIT = 7;
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_BUFFER_RESET = 8'h00;
  localparam int CLOCK_PERIOD_PS = 25000;
  localparam int HALF_BIT_NS = 5000;
  localparam int HALF_BIT_CYCLES = (HALF_BIT_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_M_START = 4'b0001,
    ST_M_LOW = 4'b0010,
    ST_M_HIGH = 4'b0011,
    ST_M_WAIT = 4'b0100,
    ST_M_STOP_LOW = 4'b0101,
    ST_M_STOP_HIGH = 4'b0110,
    ST_M_RESTART = 4'b0111,
    ST_S_BIT = 4'b1000,
    ST_S_WAIT = 4'b1001,
    ST_S_SKIP = 4'b1010,
    ST_LOST = 4'b1011
  } ctrl_state_t;
endpackage

// ---- rtl/two_wire_byte_controller.sv ----
// byte-level two-wire controller: register port, master and slave engines, pin muxing
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module two_wire_byte_controller #(
  parameter int unsigned HALF_BIT = two_wire_pkg::HALF_BIT_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic parallel_width_high_bit_in,
  input wire logic pin_position_in,
  output logic irq_out,
  input wire logic [1:0] port1_pin_in,
  input wire logic [1:0] port2_pin_in,
  input wire logic [1:0] gpio_port1_oe_in,
  input wire logic [1:0] gpio_port1_data_in,
  input wire logic [1:0] gpio_port2_oe_in,
  input wire logic [1:0] gpio_port2_data_in,
  output logic [1:0] port1_pin_oe_out,
  output logic [1:0] port1_pin_data_out,
  output logic [1:0] port2_pin_oe_out,
  output logic [1:0] port2_pin_data_out,
  output logic [1:0] port1_open_drain_out,
  output logic [1:0] port2_open_drain_out
);
  import two_wire_pkg::*;

  localparam int TIMER_W = $clog2(HALF_BIT + 1);
  // the clock's first fall after a start ends no data bit; counting wraps it to zero
  localparam logic [3:0] AFTER_START = 4'hf;

  if (HALF_BIT < 4) begin
    $error("HALF_BIT must be at least 4 cycles");
  end

  ctrl_state_t state;
  logic enable, received_stop, contest_lost_or_repeat_start, address_phase;
  logic ack, transmit, busy, master_select;
  logic [7:0] tx_byte, rx_byte, shift;
  logic [3:0] bit_cnt;
  logic byte_tx, restart_phase, bus_busy;
  logic scl_drive_low, sda_drive_low;
  logic [1:0] p1_meta, p1_sync, p2_meta, p2_sync;
  logic scl_s, sda_s, scl_prev, sda_prev;
  logic [TIMER_W-1:0] timer;
  logic timer_run, tick;
  logic use_port2;
  logic status_wr, proceed;
  logic start_seen, stop_seen, scl_rise, scl_fall;

  // pins pass two flip-flops before any logic looks at them
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      p1_meta <= 2'h3;
      p1_sync <= 2'h3;
      p2_meta <= 2'h3;
      p2_sync <= 2'h3;
    end else begin
      p1_meta <= port1_pin_in;
      p1_sync <= p1_meta;
      p2_meta <= port2_pin_in;
      p2_sync <= p2_meta;
    end
  end

  assign use_port2 = parallel_width_high_bit_in | pin_position_in;
  assign scl_s = use_port2 ? p2_sync[0] : p1_sync[0];
  assign sda_s = use_port2 ? p2_sync[1] : p1_sync[1];

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  assign start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_seen = scl_s & scl_prev & ~sda_prev & sda_s;
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bus_busy <= 1'b0;
    end else if (start_seen) begin
      bus_busy <= 1'b1;
    end else if (stop_seen) begin
      bus_busy <= 1'b0;
    end
  end

  // half-bit timer; while the clock is released, except in ST_M_START, it waits for the line to rise
  always_comb begin
    case (state)
      ST_M_START, ST_M_LOW, ST_M_STOP_LOW: timer_run = 1'b1;
      ST_M_HIGH, ST_M_STOP_HIGH: timer_run = scl_s;
      ST_M_RESTART: timer_run = restart_phase ? scl_s : 1'b1;
      default: timer_run = 1'b0;
    endcase
  end

  assign tick = timer_run && (timer == TIMER_W'(HALF_BIT - 1));

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || !timer_run || tick) begin
      timer <= '0;
    end else begin
      timer <= timer + TIMER_W'(1);
    end
  end

  assign status_wr = reg_wr_in && (reg_addr_in == STATUS_CONTROL_OFFSET) && !busy;
  assign proceed = status_wr && reg_wdata_in[PROCEED_BIT];

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      tx_byte <= BYTE_BUFFER_RESET;
    end else if (reg_wr_in && reg_addr_in == BYTE_BUFFER_OFFSET) begin
      tx_byte <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in && reg_addr_in == STATUS_CONTROL_OFFSET) begin
      reg_rdata_out <= {master_select, busy, transmit, ack, address_phase,
                        contest_lost_or_repeat_start, received_stop, enable};
    end else if (reg_rd_in && reg_addr_in == BYTE_BUFFER_OFFSET) begin
      reg_rdata_out <= rx_byte;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // control state, status bits and both bus engines
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      {master_select, busy, transmit, ack, address_phase, contest_lost_or_repeat_start,
       received_stop, enable} <= STATUS_CONTROL_RESET;
      state <= ST_IDLE;
      rx_byte <= BYTE_BUFFER_RESET;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      byte_tx <= 1'b0;
      restart_phase <= 1'b0;
      scl_drive_low <= 1'b0;
      sda_drive_low <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      irq_out <= 1'b0;
      if (status_wr) begin
        enable <= reg_wdata_in[ENABLE_BIT];
        transmit <= reg_wdata_in[TRANSMIT_BIT];
        ack <= reg_wdata_in[ACK_BIT];
        master_select <= reg_wdata_in[MASTER_SELECT_BIT];
        contest_lost_or_repeat_start <= reg_wdata_in[CONTEST_LOST_OR_REPEAT_START_BIT];
        if (proceed) begin
          address_phase <= 1'b0;
          received_stop <= 1'b0;
        end
      end
      if (!enable) begin
        state <= ST_IDLE;
        scl_drive_low <= 1'b0;
        sda_drive_low <= 1'b0;
        busy <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (master_select && !bus_busy && !start_seen) begin
              state <= ST_M_START;
              sda_drive_low <= 1'b1;
              busy <= 1'b1;
            end else if (start_seen) begin
              state <= ST_S_BIT;
              bit_cnt <= AFTER_START;
              byte_tx <= 1'b0;
              address_phase <= 1'b1;
              busy <= 1'b1;
            end
          end
          ST_M_START: begin
            if (tick) begin
              state <= ST_M_LOW;
              scl_drive_low <= 1'b1;
              bit_cnt <= 4'h0;
              byte_tx <= 1'b1;
              shift <= tx_byte;
            end
          end
          ST_M_LOW: begin
            if (bit_cnt == ACK_SLOT) begin
              sda_drive_low <= byte_tx ? 1'b0 : ack;
            end else begin
              sda_drive_low <= byte_tx ? ~shift[7] : 1'b0;
            end
            if (tick) begin
              state <= ST_M_HIGH;
              scl_drive_low <= 1'b0;
            end
          end
          ST_M_HIGH: begin
            if (tick) begin
              if (byte_tx && bit_cnt != ACK_SLOT && !sda_drive_low && !sda_s) begin
                state <= ST_LOST;
                master_select <= 1'b0;
                contest_lost_or_repeat_start <= 1'b1;
                address_phase <= 1'b1;
                sda_drive_low <= 1'b0;
              end else if (bit_cnt == ACK_SLOT) begin
                if (byte_tx) begin
                  ack <= ~sda_s;
                end
                state <= ST_M_WAIT;
                scl_drive_low <= 1'b1;
                sda_drive_low <= 1'b0;
                busy <= 1'b0;
                irq_out <= 1'b1;
              end else begin
                shift <= {shift[6:0], sda_s};
                if (bit_cnt == LAST_DATA_BIT) begin
                  rx_byte <= {shift[6:0], sda_s};
                end
                bit_cnt <= bit_cnt + 4'h1;
                state <= ST_M_LOW;
                scl_drive_low <= 1'b1;
              end
            end
          end
          ST_M_WAIT: begin
            if (proceed) begin
              busy <= 1'b1;
              if (!reg_wdata_in[MASTER_SELECT_BIT]) begin
                state <= ST_M_STOP_LOW;
                sda_drive_low <= 1'b1;
              end else if (reg_wdata_in[CONTEST_LOST_OR_REPEAT_START_BIT]) begin
                state <= ST_M_RESTART;
                restart_phase <= 1'b0;
              end else begin
                state <= ST_M_LOW;
                bit_cnt <= 4'h0;
                byte_tx <= reg_wdata_in[TRANSMIT_BIT];
                shift <= tx_byte;
              end
            end else if (status_wr && !reg_wdata_in[MASTER_SELECT_BIT]) begin
              state <= ST_M_STOP_LOW;
              sda_drive_low <= 1'b1;
              busy <= 1'b1;
            end
          end
          ST_M_RESTART: begin
            if (tick && !restart_phase) begin
              restart_phase <= 1'b1;
              scl_drive_low <= 1'b0;
            end else if (tick) begin
              state <= ST_M_START;
              sda_drive_low <= 1'b1;
              contest_lost_or_repeat_start <= 1'b0;
            end
          end
          ST_M_STOP_LOW: begin
            if (tick) begin
              state <= ST_M_STOP_HIGH;
              scl_drive_low <= 1'b0;
            end
          end
          ST_M_STOP_HIGH: begin
            if (tick) begin
              state <= ST_IDLE;
              sda_drive_low <= 1'b0;
              busy <= 1'b0;
            end
          end
          ST_S_BIT: begin
            if (stop_seen) begin
              state <= ST_IDLE;
              sda_drive_low <= 1'b0;
              busy <= 1'b0;
              if (!byte_tx) begin
                received_stop <= 1'b1;
                irq_out <= 1'b1;
              end
            end else if (start_seen) begin
              bit_cnt <= AFTER_START;
              byte_tx <= 1'b0;
              sda_drive_low <= 1'b0;
              address_phase <= 1'b1;
            end else if (scl_rise) begin
              if (bit_cnt == ACK_SLOT && byte_tx) begin
                ack <= ~sda_s;
              end else if (!byte_tx && bit_cnt != ACK_SLOT) begin
                shift <= {shift[6:0], sda_s};
              end
            end else if (scl_fall) begin
              if (!byte_tx && bit_cnt == LAST_DATA_BIT) begin
                rx_byte <= shift;
                bit_cnt <= ACK_SLOT;
                state <= ST_S_WAIT;
                scl_drive_low <= 1'b1;
                busy <= 1'b0;
                irq_out <= 1'b1;
              end else if (!byte_tx && bit_cnt == ACK_SLOT) begin
                sda_drive_low <= 1'b0;
                bit_cnt <= 4'h0;
                if (!ack) begin
                  state <= ST_S_SKIP;
                end else if (transmit) begin
                  byte_tx <= 1'b1;
                  shift <= tx_byte;
                  sda_drive_low <= ~tx_byte[7];
                end
              end else if (byte_tx && bit_cnt == ACK_SLOT) begin
                state <= ST_S_WAIT;
                scl_drive_low <= 1'b1;
                busy <= 1'b0;
                irq_out <= 1'b1;
              end else if (byte_tx && bit_cnt == LAST_DATA_BIT) begin
                bit_cnt <= ACK_SLOT;
                sda_drive_low <= 1'b0;
              end else begin
                if (byte_tx) begin
                  shift <= {shift[6:0], 1'b1};
                  sda_drive_low <= ~shift[6];
                end
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_S_WAIT: begin
            if (proceed) begin
              busy <= 1'b1;
              scl_drive_low <= 1'b0;
              state <= ST_S_BIT;
              if (!byte_tx) begin
                sda_drive_low <= reg_wdata_in[ACK_BIT];
              end else if (ack) begin
                bit_cnt <= 4'h0;
                shift <= tx_byte;
                sda_drive_low <= ~tx_byte[7];
              end else begin
                state <= ST_S_SKIP;
              end
            end
          end
          ST_S_SKIP: begin
            sda_drive_low <= 1'b0;
            if (stop_seen) begin
              state <= ST_IDLE;
              busy <= 1'b0;
            end else if (start_seen) begin
              state <= ST_S_BIT;
              bit_cnt <= AFTER_START;
              byte_tx <= 1'b0;
              address_phase <= 1'b1;
            end
          end
          ST_LOST: begin
            if (stop_seen) begin
              state <= ST_IDLE;
              busy <= 1'b0;
              irq_out <= 1'b1;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // open-drain override of the two low pins of the chosen port
  always_comb begin
    port1_open_drain_out = (enable && !use_port2) ? 2'h3 : 2'h0;
    port2_open_drain_out = (enable && use_port2) ? 2'h3 : 2'h0;
    port1_pin_oe_out = port1_open_drain_out[0] ? {sda_drive_low, scl_drive_low}
                                              : gpio_port1_oe_in;
    port1_pin_data_out = port1_open_drain_out[0] ? 2'h0 : gpio_port1_data_in;
    port2_pin_oe_out = port2_open_drain_out[0] ? {sda_drive_low, scl_drive_low}
                                              : gpio_port2_oe_in;
    port2_pin_data_out = port2_open_drain_out[0] ? 2'h0 : gpio_port2_data_in;
  end
endmodule

// ---- bench/two_wire_checker_sva.sv ----
// port-level assertions for the two-wire byte controller
`timescale 1ns/1ps
module two_wire_checker
  import two_wire_pkg::*;
#(
  parameter int unsigned HALF_BIT = 8
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic parallel_width_high_bit_in,
  input wire logic pin_position_in,
  input wire logic irq_out,
  input wire logic [1:0] gpio_port1_oe_in,
  input wire logic [1:0] gpio_port1_data_in,
  input wire logic [1:0] gpio_port2_oe_in,
  input wire logic [1:0] gpio_port2_data_in,
  input wire logic [1:0] port1_pin_oe_out,
  input wire logic [1:0] port1_pin_data_out,
  input wire logic [1:0] port2_pin_oe_out,
  input wire logic [1:0] port2_pin_data_out,
  input wire logic [1:0] port1_open_drain_out,
  input wire logic [1:0] port2_open_drain_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic od1, od2, sel, scl_low, sc_wr, wait_q;
  assign od1 = |port1_open_drain_out;
  assign od2 = |port2_open_drain_out;
  assign sel = parallel_width_high_bit_in | pin_position_in;
  assign scl_low = (od1 && port1_pin_oe_out[0]) || (od2 && port2_pin_oe_out[0]);
  assign sc_wr = reg_wr_in && reg_addr_in == STATUS_CONTROL_OFFSET;
  // set by an interrupt, cleared by the one control write that answers it
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) wait_q <= 1'b0;
    else if (irq_out) wait_q <= 1'b1;
    else if (sc_wr) wait_q <= 1'b0;
  end
  sequence sc_read;
    reg_rd_in && reg_addr_in == STATUS_CONTROL_OFFSET;
  endsequence
  sequence answer_pending;
    sc_read ##0 wait_q;
  endsequence
  AST_IRQ_PULSE: assert property (irq_out |=> !irq_out)
    else $error("interrupt pulse longer than one cycle");
  AST_RD_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside the read answer cycle");
  AST_OD_DATA: assert property ((od1 || od2) |->
    (od1 ? port1_pin_data_out : port2_pin_data_out) == 2'b00)
    else $error("open drain pin drives a high level");
  AST_GPIO1: assert property (!od1 |->
    port1_pin_oe_out == gpio_port1_oe_in && port1_pin_data_out == gpio_port1_data_in)
    else $error("port 1 pins not under gpio control");
  AST_GPIO2: assert property (!od2 |->
    port2_pin_oe_out == gpio_port2_oe_in && port2_pin_data_out == gpio_port2_data_in)
    else $error("port 2 pins not under gpio control");
  AST_SEL_P1: assert property ($stable(sel) && od1 |-> !sel)
    else $error("port 1 taken while port 2 selected");
  AST_SEL_P2: assert property ($stable(sel) && od2 |-> sel && !od1)
    else $error("port 2 taken while port 1 selected");
  AST_HOLD_IDLE: assert property ($fell(scl_low) |-> !wait_q)
    else $error("clock released before the interrupt was answered");
  AST_NO_BUSY: assert property (answer_pending |=> !reg_rdata_out[PROCEED_BIT])
    else $error("busy set again before proceed");
  AST_AFTER_RESET: assert property ($fell(reset_in) |->
    !od1 && !od2 && !irq_out && reg_rdata_out == 8'h00)
    else $error("controller not idle after reset");
endmodule
bind two_wire_byte_controller two_wire_checker #(.HALF_BIT(HALF_BIT)) two_wire_checker_i (.*);

// ---- bench/two_wire_far_slave.sv ----
// far-side two-wire slave: takes bytes, acks or refuses them, stretches the clock after each
`timescale 1ns/1ps
module two_wire_far_slave (
  input wire logic ref_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic active_in,
  input wire logic nack_in,
  output logic scl_pull_out,
  output logic sda_pull_out,
  output logic [7:0] got_out,
  output logic stop_out
);
  logic [7:0] shift = 8'h00;
  int cnt = 0;
  initial begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
    got_out = 8'h00;
    stop_out = 1'b0;
  end
  // start and stop both restart the bit count
  always @(sda_in) begin
    if (scl_in === 1'b1) begin
      cnt = 0;
      stop_out = sda_in;
    end
  end
  always @(posedge scl_in) begin
    shift = {shift[6:0], sda_in};
    cnt = cnt + 1;
  end
  // lines change one clock after the bus clock has fallen; a stretched clock is released 20 clocks after that
  always @(negedge scl_in) begin
    @(posedge ref_clk_in);
    if (cnt == 8 && active_in) begin
      got_out <= shift;
      sda_pull_out <= !nack_in;
    end else if (cnt == 9) begin
      sda_pull_out <= 1'b0;
      scl_pull_out <= active_in;
      cnt = 0;
      repeat (20) @(posedge ref_clk_in);
      scl_pull_out <= 1'b0;
    end
  end
endmodule

// ---- bench/two_wire_byte_controller_bench.sv ----
// self-checking bench: registers, pin muxing, master and slave byte transfers
`timescale 1ns/1ps
module two_wire_byte_controller_bench;
  localparam int HB = 8;
  logic clk = 1'b0;
  logic rst, wr, rd, width, pos, irq, sel, m_scl, m_sda, s_on, s_nack, s_scl, s_sda, s_stop;
  logic [7:0] addr, wdata, rdata, s_got;
  logic [1:0] p1i, p2i, g1oe, g1d, g2oe, g2d, p1oe, p1d, p2oe, p2d, od1, od2, ext, bus;
  logic [31:0] seed = 32'he65f_fe6e;
  int irq_n = 0;
  int bad_count = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  assign sel = width | pos;
  assign ext = {m_sda | s_sda, m_scl | s_scl};
  assign p1i = ~(p1oe & ~p1d) & ~(sel ? 2'b00 : ext);
  assign p2i = ~(p2oe & ~p2d) & ~(sel ? ext : 2'b00);
  assign bus = sel ? p2i : p1i;
  two_wire_byte_controller #(.HALF_BIT(HB)) two_wire_byte_controller_i (
    .ref_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .parallel_width_high_bit_in(width), .pin_position_in(pos), .irq_out(irq),
    .port1_pin_in(p1i), .port2_pin_in(p2i), .gpio_port1_oe_in(g1oe),
    .gpio_port1_data_in(g1d), .gpio_port2_oe_in(g2oe), .gpio_port2_data_in(g2d),
    .port1_pin_oe_out(p1oe), .port1_pin_data_out(p1d), .port2_pin_oe_out(p2oe),
    .port2_pin_data_out(p2d), .port1_open_drain_out(od1), .port2_open_drain_out(od2));
  two_wire_far_slave two_wire_far_slave_i (
    .ref_clk_in(clk), .scl_in(bus[0]), .sda_in(bus[1]), .active_in(s_on),
    .nack_in(s_nack), .scl_pull_out(s_scl), .sda_pull_out(s_sda), .got_out(s_got),
    .stop_out(s_stop));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_od(input logic w, input logic p);
    return (w | p) ? 8'h0c : 8'h03;
  endfunction
  // gpio drives only high levels so it never disturbs the two-wire bus
  always @(posedge clk) begin
    seed <= lfsr(seed);
    g1oe <= seed[1:0];
    g1d <= seed[3:2] | seed[1:0];
    g2oe <= seed[5:4];
    g2d <= seed[7:6] | seed[5:4];
    if (irq === 1'b1) irq_n <= irq_n + 1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    check(rdata & m, e);
  endtask
  task automatic wait_irq;
    int n0;
    n0 = irq_n;
    for (int k = 0; k < 3000 && irq_n == n0; k++) @(posedge clk);
    check(8'(irq_n - n0), 8'h01);
  endtask
  // bench as outside master: 4 cycles low, 5 high, waits while the clock is stretched
  task automatic m_bit(input logic v, output logic s);
    @(posedge clk);
    m_sda <= !v;
    repeat (3) @(posedge clk);
    m_scl <= 1'b0;
    for (int k = 0; k < 4000 && !bus[0]; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    s = bus[1];
    m_scl <= 1'b1;
  endtask
  task automatic m_byte(input logic [7:0] b);
    logic s;
    m_sda <= 1'b1;
    repeat (4) @(posedge clk);
    m_scl <= 1'b1;
    for (int i = 7; i >= 0; i--) m_bit(b[i], s);
  endtask
  // data pulled low under a low clock, clock released, then data released while it is high
  task automatic m_stop;
    @(posedge clk);
    m_sda <= 1'b1;
    repeat (3) @(posedge clk);
    m_scl <= 1'b0;
    for (int k = 0; k < 4000 && !bus[0]; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    m_sda <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    wrap_up;
  end
  initial begin
    logic [7:0] b;
    logic a;
    int n0;
    {rst, addr, wdata, wr, rd, width, pos} <= {1'b1, 20'h0_0000};
    {m_scl, m_sda, s_on, s_nack} <= 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(8'h28, 8'hff, 8'h00);
    rd_chk(8'h29, 8'hff, 8'h00);
    rd_chk(8'h2a, 8'hff, 8'h00);
    for (int i = 0; i < 4; i++) begin
      width <= i[1];
      pos <= i[0];
      reg_wr(8'h28, 8'h01);
      check({4'h0, od2, od1}, exp_od(i[1], i[0]));
      reg_wr(8'h28, 8'h00);
      check({4'h0, od2, od1}, 8'h00);
    end
    s_on <= 1'b1;
    reg_wr(8'h28, 8'h01);
    b = {seed[7:1], 1'b0};
    reg_wr(8'h29, b);
    reg_wr(8'h28, 8'h81);
    wait_irq;
    check(s_got, b);
    rd_chk(8'h28, 8'hdf, 8'h91);
    for (int j = 0; j < 2; j++) begin
      b = seed[7:0];
      reg_wr(8'h29, b);
      reg_wr(8'h28, 8'he1);
      reg_wr(8'h28, 8'h01);
      wait_irq;
      check(s_got, b);
      rd_chk(8'h28, 8'hde, 8'h90);
    end
    b = {seed[7:1], 1'b0};
    reg_wr(8'h29, b);
    reg_wr(8'h28, 8'hc5);
    wait_irq;
    check({7'h00, s_stop}, 8'h00);
    check(s_got, b);
    rd_chk(8'h28, 8'h84, 8'h80);
    s_nack <= 1'b1;
    reg_wr(8'h29, seed[7:0]);
    reg_wr(8'h28, 8'he1);
    wait_irq;
    rd_chk(8'h28, 8'h10, 8'h00);
    reg_wr(8'h28, 8'h21);
    repeat (100) @(posedge clk);
    check({7'h00, s_stop}, 8'h01);
    s_on <= 1'b0;
    s_nack <= 1'b0;
    reg_wr(8'h28, 8'h00);
    width <= 1'b0;
    pos <= 1'b0;
    reg_wr(8'h28, 8'h01);
    b = seed[7:0];
    m_byte(b);
    wait_irq;
    rd_chk(8'h28, 8'hff, 8'h09);
    rd_chk(8'h29, 8'hff, b);
    reg_wr(8'h28, 8'h51);
    m_bit(1'b1, a);
    check({7'h00, a}, 8'h00);
    b = seed[15:8];
    for (int i = 7; i >= 0; i--) m_bit(b[i], a);
    wait_irq;
    rd_chk(8'h29, 8'hff, b);
    rd_chk(8'h28, 8'h4e, 8'h00);
    reg_wr(8'h28, 8'h51);
    m_bit(1'b1, a);
    m_stop;
    wait_irq;
    rd_chk(8'h28, 8'h02, 8'h02);
    reg_wr(8'h28, 8'h41);
    m_byte(seed[7:0]);
    wait_irq;
    reg_wr(8'h28, 8'h41);
    m_bit(1'b1, a);
    check({7'h00, a}, 8'h01);
    n0 = irq_n;
    m_stop;
    repeat (40) @(posedge clk);
    check(8'(irq_n - n0), 8'h00);
    rd_chk(8'h28, 8'h02, 8'h00);
    wrap_up;
  end
endmodule
